/* hw/udc_pkg.sv */
// udc_pkg: constants and carrier types for the data-flow command decoder.
// assumes a 16-bit processor bus with a command/data select line.
package udc_pkg;

  localparam int UDC_NUM_EP = 16;
  localparam int UDC_DW = 16;

  // command groups, upper nibble of the code
  localparam logic [3:0] UDC_GRP_WRBUF = 4'h0;
  localparam logic [3:0] UDC_GRP_RDBUF = 4'h1;
  localparam logic [3:0] UDC_GRP_STALL = 4'h4;
  localparam logic [3:0] UDC_GRP_STAT = 4'h5;
  localparam logic [3:0] UDC_GRP_VALID = 4'h6;
  localparam logic [3:0] UDC_GRP_CLEAR = 4'h7;
  localparam logic [3:0] UDC_GRP_UNSTALL = 4'h8;
  localparam logic [3:0] UDC_GRP_CHECK = 4'hd;

  // endpoint indexes: 0 control OUT, 1 control IN, 2..15 endpoints 1..14
  localparam logic [3:0] UDC_EP_CTRL_OUT = 4'h0;
  localparam logic [3:0] UDC_EP_CTRL_IN = 4'h1;

  // payload byte limits
  localparam logic [10:0] UDC_MAX_CTRL = 11'h040;
  localparam logic [10:0] UDC_MAX_BULK = 11'h040;
  localparam logic [10:0] UDC_MAX_ISO = 11'h3ff;
  // the length prefix occupies this many bytes ahead of the payload
  localparam logic [10:0] UDC_LEN_BYTES = 11'h002;

  typedef enum logic [2:0] {
    UDC_ST_IDLE = 3'b000,
    UDC_ST_WR = 3'b001,
    UDC_ST_RD = 3'b010,
    UDC_ST_STAT = 3'b011
  } udc_state_t;

  // processor bus cycle
  typedef struct packed {
    logic wr;
    logic rd;
    logic cmd_data_select;
    logic [15:0] data;
  } udc_bus_t;

  // request to the endpoint buffer memory
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] ep;
    logic [9:0] word;
    logic [15:0] data;
  } udc_buf_t;

  // one-cycle endpoint actions
  typedef struct packed {
    logic stall;
    logic unstall;
    logic validate;
    logic clear;
    logic status_clear;
    logic [3:0] ep;
  } udc_act_t;

  typedef struct packed {
    udc_state_t st;
    logic [3:0] ep;
    logic [9:0] word;
    logic [9:0] words;
    logic [15:0] rdata;
    logic rvalid;
    logic illegal;
    udc_buf_t buf_req;
    udc_act_t act;
  } udc_regs_t;

endpackage

/* hw/udc_dataflow_decoder.sv */
// udc_dataflow_decoder: decodes data-flow commands from the processor bus
// into endpoint buffer accesses and endpoint actions.
// assumes bus strobes are single-cycle and synchronous; buffer memory
// returns read data combinationally for the addressed word.
`timescale 1ns/1ps
module udc_dataflow_decoder
  import udc_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // processor bus
  input udc_pkg::udc_bus_t bus,
  output logic [15:0] rd_data,
  output logic rd_valid,
  output logic cmd_illegal,
  // endpoint configuration: iso flag per endpoint
  input wire logic [15:0] ep_iso,
  // endpoint status
  input wire logic [15:0] endpoint_status_reg,
  // buffer memory
  output udc_pkg::udc_buf_t buf_req,
  input wire logic [15:0] buf_rdata,
  // endpoint actions
  output udc_pkg::udc_act_t ep_act
);
  import udc_pkg::*;

  udc_regs_t s_reg;
  udc_regs_t s_next;
  logic [3:0] grp;
  logic [3:0] epi;
  logic [10:0] limit;
  logic [9:0] lim_words;

  assign grp = bus.data[7:4];
  assign epi = bus.data[3:0];

  // ------------------------------------------------------------
  // command decode and data phase
  // ------------------------------------------------------------
  always_comb
  begin
    s_next = s_reg;
    s_next.rvalid = 1'b0;
    s_next.illegal = 1'b0;
    s_next.buf_req.wr = 1'b0;
    s_next.buf_req.rd = 1'b0;
    s_next.act = '0;
    limit = (epi < 4'h2) ? UDC_MAX_CTRL : (ep_iso[epi] ? UDC_MAX_ISO : UDC_MAX_BULK);
    // prefix plus payload, rounded up to words
    lim_words = 10'((limit + UDC_LEN_BYTES + 11'h001) >> 1);
    if (bus.wr && bus.cmd_data_select)
    begin
      s_next.st = UDC_ST_IDLE;
      s_next.ep = epi;
      s_next.word = '0;
      s_next.words = lim_words;
      s_next.act.ep = epi;
      // present word 0 so the first read finds its data waiting
      s_next.buf_req.ep = epi;
      s_next.buf_req.word = '0;
      unique case (grp)
        UDC_GRP_WRBUF:
          if (epi == UDC_EP_CTRL_OUT) s_next.illegal = 1'b1;
          else s_next.st = UDC_ST_WR;
        UDC_GRP_RDBUF:
          if (epi == UDC_EP_CTRL_IN) s_next.illegal = 1'b1;
          else s_next.st = UDC_ST_RD;
        UDC_GRP_STALL: s_next.act.stall = 1'b1;
        UDC_GRP_STAT:
        begin
          s_next.st = UDC_ST_STAT;
          s_next.rdata = endpoint_status_reg;
          s_next.act.status_clear = 1'b1;
        end
        UDC_GRP_VALID:
          if (epi == UDC_EP_CTRL_OUT) s_next.illegal = 1'b1;
          else s_next.act.validate = 1'b1;
        UDC_GRP_CLEAR:
          if (epi == UDC_EP_CTRL_IN) s_next.illegal = 1'b1;
          else s_next.act.clear = 1'b1;
        UDC_GRP_UNSTALL: s_next.act.unstall = 1'b1;
        UDC_GRP_CHECK:
        begin
          // copy of status, no clear pulse issued
          s_next.st = UDC_ST_STAT;
          s_next.rdata = endpoint_status_reg;
        end
        default: s_next.illegal = 1'b1;
      endcase
      // refused codes leave nothing on the action port
      if (s_next.illegal) s_next.act.ep = '0;
    end
    else if ((bus.wr || bus.rd) && !bus.cmd_data_select)
    begin
      unique case (s_reg.st)
        UDC_ST_WR:
          if (bus.wr)
          begin
            s_next.buf_req.wr = 1'b1;
            s_next.buf_req.ep = s_reg.ep;
            s_next.buf_req.word = s_reg.word;
            s_next.buf_req.data = bus.data;
            s_next.word = s_reg.word + 10'h001;
            // reaching the word limit ends the phase; later data words are dropped
            if (s_next.word == s_reg.words) s_next.st = UDC_ST_IDLE;
          end
        UDC_ST_RD:
          if (bus.rd)
          begin
            s_next.buf_req.rd = 1'b1;
            s_next.buf_req.ep = s_reg.ep;
            s_next.rdata = buf_rdata;
            s_next.rvalid = 1'b1;
            s_next.word = s_reg.word + 10'h001;
            // address runs one word ahead: memory answers combinationally,
            // so back-to-back reads each find their word already there
            s_next.buf_req.word = s_next.word;
            if (s_next.word == s_reg.words) s_next.st = UDC_ST_IDLE;
          end
        UDC_ST_STAT:
          if (bus.rd)
          begin
            s_next.rvalid = 1'b1;
            s_next.st = UDC_ST_IDLE;
          end
        UDC_ST_IDLE: s_next.st = UDC_ST_IDLE;
        default: s_next.st = UDC_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock)
  begin
    if (reset)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign rd_data = s_reg.rdata;
  assign rd_valid = s_reg.rvalid;
  assign cmd_illegal = s_reg.illegal;
  assign buf_req = s_reg.buf_req;
  assign ep_act = s_reg.act;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_no_data_stall;
    @(posedge clock) disable iff (reset)
    (bus.wr && bus.cmd_data_select && grp == UDC_GRP_STALL)
      |=> ep_act.stall && s_reg.st == UDC_ST_IDLE && !buf_req.wr;
  endproperty
  a_no_data_stall: assert property (p_no_data_stall) else $error("stall bad");

  property p_unstall;
    @(posedge clock) disable iff (reset)
    (bus.wr && bus.cmd_data_select && grp == UDC_GRP_UNSTALL)
      |=> ep_act.unstall && ep_act.ep == $past(epi);
  endproperty
  a_unstall: assert property (p_unstall) else $error("unstall bad");

  property p_illegal00;
    @(posedge clock) disable iff (reset)
    (bus.wr && bus.cmd_data_select && bus.data[7:0] == 8'h00)
      |=> cmd_illegal && s_reg.st == UDC_ST_IDLE;
  endproperty
  a_illegal00: assert property (p_illegal00) else $error("code 00 accepted");

  property p_validate;
    @(posedge clock) disable iff (reset)
    (bus.wr && bus.cmd_data_select && grp == UDC_GRP_VALID && epi != 4'h0)
      |=> ep_act.validate && !ep_act.clear;
  endproperty
  a_validate: assert property (p_validate) else $error("validate bad");

  property p_clear;
    @(posedge clock) disable iff (reset)
    (bus.wr && bus.cmd_data_select && grp == UDC_GRP_CLEAR && epi != 4'h1)
      |=> ep_act.clear && !ep_act.validate;
  endproperty
  a_clear: assert property (p_clear) else $error("clear bad");

  property p_stat_clears;
    @(posedge clock) disable iff (reset)
    (bus.wr && bus.cmd_data_select && grp == UDC_GRP_STAT)
      |=> ep_act.status_clear && rd_data == $past(endpoint_status_reg);
  endproperty
  a_stat_clears: assert property (p_stat_clears) else $error("status read bad");

  property p_check_keeps;
    @(posedge clock) disable iff (reset)
    (bus.wr && bus.cmd_data_select && grp == UDC_GRP_CHECK)
      |=> !ep_act.status_clear && rd_data == $past(endpoint_status_reg);
  endproperty
  a_check_keeps: assert property (p_check_keeps) else $error("copy read cleared");

  property p_ctrl_words;
    @(posedge clock) disable iff (reset)
    (bus.wr && bus.cmd_data_select && bus.data[7:0] == 8'h01) |=> s_reg.words == 10'h021;
  endproperty
  a_ctrl_words: assert property (p_ctrl_words) else $error("control word count");

  property p_iso_words;
    @(posedge clock) disable iff (reset)
    (bus.wr && bus.cmd_data_select && grp == UDC_GRP_WRBUF && epi > 4'h1 && ep_iso[epi])
      |=> s_reg.words == 10'h201;
  endproperty
  a_iso_words: assert property (p_iso_words) else $error("iso word count");

  property p_rd_data;
    @(posedge clock) disable iff (reset)
    (s_reg.st == UDC_ST_RD && bus.rd && !bus.cmd_data_select)
      |=> rd_valid && buf_req.rd && rd_data == $past(buf_rdata);
  endproperty
  a_rd_data: assert property (p_rd_data) else $error("buffer read bad");

endmodule

/* verif/udc_mem_model.sv */
// udc_mem_model: endpoint buffer memory standing behind the decoder.
// assumes one write per buf_req.wr pulse; read data follows the address.
`timescale 1ns/1ps
module udc_mem_model
  import udc_pkg::*;
(
  // clock
  input wire logic clock,
  // buffer port
  input wire udc_pkg::udc_buf_t buf_req,
  output logic [15:0] buf_rdata
);
  import udc_pkg::*;
  // only 16 words per endpoint kept, enough for short packets
  logic [15:0] mem [256];
  initial
  begin
    foreach (mem[i]) mem[i] = 16'(i) ^ 16'h5a5a;
  end
  // word 0 of each endpoint holds the length prefix
  always @(posedge clock)
  begin
    if (buf_req.wr) mem[{buf_req.ep, buf_req.word[3:0]}] <= buf_req.data;
  end
  assign buf_rdata = mem[{buf_req.ep, buf_req.word[3:0]}];
endmodule

/* verif/tb_usb_device_dataflow_cmd_decoder.sv */
// tb_usb_device_dataflow_cmd_decoder: directed scenarios for the decoder.
// assumes answers land at the taking edge, one cycle after the strobe is driven, and are visible just after it.
`timescale 1ns/1ps
module tb_usb_device_dataflow_cmd_decoder;
  import udc_pkg::*;
  logic clock = 1'b0;
  logic reset = 1'b1;
  udc_bus_t bus = '0;
  logic [15:0] endpoint_status_reg = 16'h0000;
  logic [15:0] rd_data;
  logic [15:0] buf_rdata;
  logic rd_valid;
  logic cmd_illegal;
  udc_buf_t buf_req;
  udc_act_t ep_act;
  int n_errors = 0;
  int samples_checked = 0;
  always #20 clock = ~clock;
  udc_dataflow_decoder i_dut (.clock(clock), .reset(reset), .bus(bus),
    .rd_data(rd_data), .rd_valid(rd_valid), .cmd_illegal(cmd_illegal),
    .ep_iso(16'h0004), .endpoint_status_reg(endpoint_status_reg),
    .buf_req(buf_req), .buf_rdata(buf_rdata), .ep_act(ep_act));
  udc_mem_model i_mem (.clock(clock), .buf_req(buf_req), .buf_rdata(buf_rdata));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    samples_checked++;
    if (s !== e)
    begin
      $display("BAD %s expected %h seen %h", nm, e, s);
      n_errors++;
    end
  endtask
  // one strobe, taken at the second edge; outputs visible on return
  task automatic cyc(input logic w, input logic r, input logic c, input logic [15:0] d);
    @(posedge clock);
    #1 bus = {w, r, c, d};
    @(posedge clock);
    #1 bus = '0;
  endtask
  task automatic final_report();
    if (n_errors == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_write();
    logic [7:0] codes [3] = '{8'h01, 8'h02, 8'h0f};
    foreach (codes[i])
    begin
      cyc(1'b1, 1'b0, 1'b1, {8'h00, codes[i]});
      chk("cmd_illegal", 16'h0, 16'(cmd_illegal));
      cyc(1'b1, 1'b0, 1'b0, 16'h0003);
      chk("wr0", {1'b1, 1'b0, codes[i][3:0], 10'h000}, buf_req[31:16]);
      chk("wr0 data", 16'h0003, buf_req.data);
      cyc(1'b1, 1'b0, 1'b0, 16'hbeef);
      chk("wr1", {1'b1, 1'b0, codes[i][3:0], 10'h001}, buf_req[31:16]);
      chk("wr1 data", 16'hbeef, buf_req.data);
    end
  endtask
  // bulk limit: 64 payload bytes plus prefix is 33 words, the 34th is dropped
  task automatic t_limit();
    cyc(1'b1, 1'b0, 1'b1, 16'h000e);
    for (int i = 0; i < 33; i++)
    begin
      cyc(1'b1, 1'b0, 1'b0, 16'(i));
    end
    chk("last wr", {1'b1, 1'b0, 4'he, 10'h020}, buf_req[31:16]);
    cyc(1'b1, 1'b0, 1'b0, 16'h2222);
    chk("past limit", 16'h0, 16'(buf_req.wr));
  endtask
  task automatic t_actions();
    logic [7:0] codes [10] = '{8'h40, 8'h41, 8'h4f, 8'h80, 8'h81, 8'h8f,
      8'h61, 8'h6f, 8'h70, 8'h7f};
    logic [3:0] k;
    foreach (codes[i])
    begin
      k = codes[i][7:4];
      cyc(1'b1, 1'b0, 1'b1, {8'h00, codes[i]});
      chk("ep_act", {7'h0, k == 4'h4, k == 4'h8, k == 4'h6, k == 4'h7, 1'b0,
        codes[i][3:0]}, 16'(ep_act));
      // no data phase: a stray data word must not reach the buffer
      cyc(1'b1, 1'b0, 1'b0, 16'h1111);
      chk("stray wr", 16'h0, 16'(buf_req.wr));
    end
  endtask
  task automatic t_illegal();
    logic [7:0] codes [6] = '{8'h00, 8'h11, 8'h60, 8'h71, 8'h90, 8'he3};
    foreach (codes[i])
    begin
      cyc(1'b1, 1'b0, 1'b1, {8'h00, codes[i]});
      chk("cmd_illegal", 16'h1, 16'(cmd_illegal));
      chk("ep_act", 16'h0, 16'(ep_act));
      chk("buf_req", 16'h0, {14'h0, buf_req.wr, buf_req.rd});
    end
  endtask
  task automatic t_status(input logic [7:0] code, input logic [15:0] st);
    endpoint_status_reg = st;
    cyc(1'b1, 1'b0, 1'b1, {8'h00, code});
    chk("status act", {7'h0, 4'h0, code[7:4] == 4'h5, code[3:0]}, 16'(ep_act));
    endpoint_status_reg = ~st;
    cyc(1'b0, 1'b1, 1'b0, 16'h0000);
    chk("rd_valid", 16'h1, 16'(rd_valid));
    chk("rd_data", st, rd_data);
  endtask
  task automatic t_read(input logic [7:0] code, input logic [15:0] w0, input logic [15:0] w1);
    cyc(1'b1, 1'b0, 1'b1, {8'h00, code});
    cyc(1'b0, 1'b1, 1'b0, 16'h0000);
    chk("read valid", 16'h2, 16'({rd_valid, cmd_illegal}));
    chk("read word0", w0, rd_data);
    cyc(1'b0, 1'b1, 1'b0, 16'h0000);
    chk("read word1", w1, rd_data);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    repeat (6) @(posedge clock);
    #1 reset = 1'b0;
    chk("after reset", 16'h0, {13'h0, rd_valid, cmd_illegal, buf_req.wr});
    t_write();
    t_limit();
    t_actions();
    t_illegal();
    t_status(8'h52, 16'h1c5a);
    t_status(8'h50, 16'h0a0a);
    t_status(8'hd3, 16'h0f0f);
    t_status(8'hd0, 16'h8001);
    // control OUT still holds the model's fill pattern
    t_read(8'h10, 16'h5a5a, 16'h5a5b);
    // index 15 holds what t_write left there
    t_read(8'h1f, 16'h0003, 16'hbeef);
    final_report();
  end
  initial
  begin
    #2000000;
    n_errors++;
    final_report();
  end
endmodule
